// file: core/tcic_consts.svh
// Register offsets, field positions, reset values and fixed counts for the capture timer.
`ifndef TCIC_CONSTS_SVH
`define TCIC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets on the 8-bit register port
// ----------------------------------------------------------------------------
`define TCIC_ADDR_W        4
`define TCIC_ADDR_CTRL_A   4'h0
`define TCIC_ADDR_CTRL_B   4'h1
`define TCIC_ADDR_CNT_LO   4'h2
`define TCIC_ADDR_CNT_HI   4'h3
`define TCIC_ADDR_CAP_LO   4'h4
`define TCIC_ADDR_CAP_HI   4'h5
`define TCIC_ADDR_CMPA_LO  4'h6
`define TCIC_ADDR_CMPA_HI  4'h7
`define TCIC_ADDR_FLAGS    4'h8
`define TCIC_ADDR_IRQ_EN   4'h9
`define TCIC_ADDR_CMP_CS   4'hA

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TCIC_CA_WGM_MSB    1
`define TCIC_CB_CS_MSB     2
`define TCIC_CB_WGM_LSB    3
`define TCIC_CB_WGM_MSB    4
`define TCIC_CB_EDGE_BIT   6
`define TCIC_CB_NF_BIT     7
`define TCIC_FLAG_OVF_BIT  0
`define TCIC_FLAG_CAP_BIT  5
`define TCIC_CS_COMPARATOR_CAPTURE_SELECT_BIT   2

// ----------------------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------------------
`define TCIC_RST_BYTE      8'h00
`define TCIC_RST_WORD      16'h0000
`define TCIC_BOTTOM        16'h0000
`define TCIC_MAX           16'hFFFF
`define TCIC_TOP_8BIT      16'h00FF
`define TCIC_TOP_9BIT      16'h01FF
`define TCIC_TOP_10BIT     16'h03FF
`define TCIC_CS_STOP       3'h0
`define TCIC_NF_SAMPLES    4

`endif

// file: core/tcic_pkg.sv
// Types shared by the capture timer modules.
package tcic_pkg;

  typedef enum logic [3:0] {
    TCIC_WGM_NORMAL    = 4'h0,
    TCIC_WGM_PC8       = 4'h1,
    TCIC_WGM_PC9       = 4'h2,
    TCIC_WGM_PC10      = 4'h3,
    TCIC_WGM_CTC_CMPA  = 4'h4,
    TCIC_WGM_FAST8     = 4'h5,
    TCIC_WGM_FAST9     = 4'h6,
    TCIC_WGM_FAST10    = 4'h7,
    TCIC_WGM_PFC_CAP   = 4'h8,
    TCIC_WGM_PFC_CMPA  = 4'h9,
    TCIC_WGM_PC_CAP    = 4'hA,
    TCIC_WGM_PC_CMPA   = 4'hB,
    TCIC_WGM_CTC_CAP   = 4'hC,
    TCIC_WGM_RESERVED  = 4'hD,
    TCIC_WGM_FAST_CAP  = 4'hE,
    TCIC_WGM_FAST_CMPA = 4'hF
  } tcic_wgm_t;

endpackage

// file: core/tcic_noise_filter.sv
// Capture noise filter and edge detector on the system clock.
`timescale 1ns/10ps
`include "tcic_consts.svh"

module tcic_noise_filter
  import tcic_pkg::*;
(
  input  wire logic CLOCK,
  input  wire logic SRST,
  input  wire logic sample_in,
  input  wire logic filter_en,
  input  wire logic rise_sel,
  output logic      edge_out
);

  logic [`TCIC_NF_SAMPLES-1:0] hist_ff;
  logic                        filt_ff;
  logic                        prev_ff;

  wire all_hi   = &hist_ff;
  wire all_lo   = ~|hist_ff;
  // With the filter enabled, the filtered level moves only once the whole sample window agrees; bypassed, it follows the input.
  wire nxt_filt = filter_en ? (all_hi ? 1'b1 : (all_lo ? 1'b0 : filt_ff)) : sample_in;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      hist_ff <= '0;
      filt_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      hist_ff <= {hist_ff[`TCIC_NF_SAMPLES-2:0], sample_in};
      filt_ff <= nxt_filt;
      prev_ff <= filt_ff;
    end
  end

  assign edge_out = rise_sel ? (filt_ff & ~prev_ff) : (~filt_ff & prev_ff);

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  property p_filter_hold;
    filter_en && !all_hi && !all_lo |=> $stable(filt_ff);
  endproperty
  a_filter_hold: assert property (p_filter_hold) else $error("Filter output moved without agreement.");

  property p_filter_bypass;
    !filter_en |=> filt_ff == $past(sample_in);
  endproperty
  a_filter_bypass: assert property (p_filter_bypass) else $error("Bypassed filter did not follow input.");

  property p_filter_delay;
    filter_en && $rose(sample_in) ##1 sample_in [*4] |=> filt_ff;
  endproperty
  a_filter_delay: assert property (p_filter_delay) else $error("Filter output late after stable input.");

endmodule

// file: core/tcic_timer.sv
// 16-bit up/down timer with input capture behind an 8-bit register port.
//
// Operation
// - Tick source select; zero stops counter.
// - 16-bit counter clears, increments or decrements.
// - Counter low read copies high into holding.
// - Counter low write loads holding and data.
// - Software counter write beats counting.
// - Counter accessible with or without tick.
// - Four-bit mode split over both controls.
// - Overflow flag set per mode; interrupt capable.
// - Capture copies counter and sets flag together.
// - Enabled flag requests interrupt; service clears it.
// - Writing one clears capture flag.
// - Capture low read latches high byte.
// - Capture writable only when it sets top.
// - Pin triggers; comparator optional on first instance.
// - Filter needs four equal samples; edge follows.
// - Filter on system clock adds four cycles.
// - Filter enable bit in control B.
// - Capture input off in capture-top modes.
// - Software-driven pin edges also capture.
// - New capture overwrites unread capture value.
// - One shared holding byte for all words.
// - Top is fixed, capture or compare A.
`timescale 1ns/10ps
`include "tcic_consts.svh"

module tcic_timer
  import tcic_pkg::*;
#(
  parameter bit HAS_COMPARATOR = 1'b1
)(
  input  wire logic                    CLOCK,
  input  wire logic                    SRST,
  input  wire logic [`TCIC_ADDR_W-1:0] ADDR,
  input  wire logic                    WR_EN,
  input  wire logic                    RD_EN,
  input  wire logic [7:0]              WDATA,
  output logic      [7:0]              RDATA,
  input  wire logic [6:0]              TICK_IN,
  input  wire logic                    CAPTURE_INPUT_PIN,
  input  wire logic                    COMPARATOR_OUTPUT,
  output logic                         CAPTURE_IRQ,
  input  wire logic                    CAPTURE_IRQ_ACK,
  output logic                         OVERFLOW_IRQ,
  input  wire logic                    OVERFLOW_IRQ_ACK
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  function automatic logic hit(input logic [`TCIC_ADDR_W-1:0] a,
                               input logic [`TCIC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [15:0] mode_top(input tcic_wgm_t m,
                                           input logic [15:0] cap,
                                           input logic [15:0] cmpa);
    case (m)
      TCIC_WGM_PC8, TCIC_WGM_FAST8:   mode_top = `TCIC_TOP_8BIT;
      TCIC_WGM_PC9, TCIC_WGM_FAST9:   mode_top = `TCIC_TOP_9BIT;
      TCIC_WGM_PC10, TCIC_WGM_FAST10: mode_top = `TCIC_TOP_10BIT;
      TCIC_WGM_CTC_CMPA, TCIC_WGM_PFC_CMPA,
      TCIC_WGM_PC_CMPA, TCIC_WGM_FAST_CMPA: mode_top = cmpa;
      TCIC_WGM_PFC_CAP, TCIC_WGM_PC_CAP,
      TCIC_WGM_CTC_CAP, TCIC_WGM_FAST_CAP:  mode_top = cap;
      default:                        mode_top = `TCIC_MAX;
    endcase
  endfunction

  function automatic logic mode_dual(input tcic_wgm_t m);
    case (m)
      TCIC_WGM_PC8, TCIC_WGM_PC9, TCIC_WGM_PC10, TCIC_WGM_PFC_CAP,
      TCIC_WGM_PFC_CMPA, TCIC_WGM_PC_CAP, TCIC_WGM_PC_CMPA: mode_dual = 1'b1;
      default: mode_dual = 1'b0;
    endcase
  endfunction

  function automatic logic mode_fast(input tcic_wgm_t m);
    case (m)
      TCIC_WGM_FAST8, TCIC_WGM_FAST9, TCIC_WGM_FAST10,
      TCIC_WGM_FAST_CAP, TCIC_WGM_FAST_CMPA: mode_fast = 1'b1;
      default: mode_fast = 1'b0;
    endcase
  endfunction

  function automatic logic mode_cap_top(input tcic_wgm_t m);
    case (m)
      TCIC_WGM_PFC_CAP, TCIC_WGM_PC_CAP,
      TCIC_WGM_CTC_CAP, TCIC_WGM_FAST_CAP: mode_cap_top = 1'b1;
      default: mode_cap_top = 1'b0;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [1:0]  wgm_lo_ff;
  logic [1:0]  wgm_hi_ff;
  logic [2:0]  tick_sel_ff;
  logic        edge_rise_ff;
  logic        nf_en_ff;
  logic        cap_ie_ff;
  logic        ovf_ie_ff;
  logic        cmp_sel_ff;
  logic        cap_flag_ff;
  logic        ovf_flag_ff;
  logic [7:0]  hold_ff;
  logic [15:0] cnt_ff;
  logic [15:0] cap_ff;
  logic [15:0] cmpa_ff;
  logic        down_ff;
  logic [7:0]  rdata_ff;
  logic        sync1_ff;
  logic        sync2_ff;

  // --------------------------------------------------------------------------
  // Register port decode
  // --------------------------------------------------------------------------
  wire wr_ctrl_a  = WR_EN && hit(ADDR, `TCIC_ADDR_CTRL_A);
  wire wr_ctrl_b  = WR_EN && hit(ADDR, `TCIC_ADDR_CTRL_B);
  wire wr_cnt_lo  = WR_EN && hit(ADDR, `TCIC_ADDR_CNT_LO);
  wire wr_cap_lo  = WR_EN && hit(ADDR, `TCIC_ADDR_CAP_LO);
  wire wr_cmpa_lo = WR_EN && hit(ADDR, `TCIC_ADDR_CMPA_LO);
  wire wr_flags   = WR_EN && hit(ADDR, `TCIC_ADDR_FLAGS);
  wire wr_irq_en  = WR_EN && hit(ADDR, `TCIC_ADDR_IRQ_EN);
  wire wr_cmp_cs  = WR_EN && hit(ADDR, `TCIC_ADDR_CMP_CS);
  // Every high-byte location lands in the single shared holding byte.
  wire wr_hi_any  = WR_EN && (hit(ADDR, `TCIC_ADDR_CNT_HI) || hit(ADDR, `TCIC_ADDR_CAP_HI) ||
                              hit(ADDR, `TCIC_ADDR_CMPA_HI));
  wire rd_cnt_lo  = RD_EN && hit(ADDR, `TCIC_ADDR_CNT_LO);
  wire rd_cap_lo  = RD_EN && hit(ADDR, `TCIC_ADDR_CAP_LO);

  // --------------------------------------------------------------------------
  // Mode and tick selection
  // --------------------------------------------------------------------------
  wire tcic_wgm_t wgm     = tcic_wgm_t'({wgm_hi_ff, wgm_lo_ff});
  wire [15:0]     top     = mode_top(wgm, cap_ff, cmpa_ff);
  wire            dual    = mode_dual(wgm);
  wire            cap_top = mode_cap_top(wgm);
  // The prescaler lives outside; a zero select leaves the counter frozen.
  wire tick = (tick_sel_ff != `TCIC_CS_STOP) && TICK_IN[tick_sel_ff - 3'h1];
  wire at_top = (cnt_ff == top);
  wire at_bot = (cnt_ff == `TCIC_BOTTOM);

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  wire turn_down  = dual && !down_ff && at_top;
  wire turn_up    = dual && down_ff && at_bot;
  wire go_down    = (down_ff && !turn_up) || turn_down;
  wire [15:0] cnt_step = go_down ? (cnt_ff - 16'h0001) : (cnt_ff + 16'h0001);
  wire [15:0] cnt_tick = (!dual && at_top) ? `TCIC_BOTTOM : cnt_step;
  wire ovf_cond   = dual ? at_bot : (mode_fast(wgm) ? at_top : (cnt_ff == `TCIC_MAX));
  wire count_en   = tick && !wr_cnt_lo;
  wire ovf_set    = count_en && ovf_cond;

  wire [15:0] nxt_cnt  = wr_cnt_lo ? {hold_ff, WDATA} : (count_en ? cnt_tick : cnt_ff);
  wire        nxt_down = !dual ? 1'b0 : (count_en ? go_down : down_ff);

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      cnt_ff  <= `TCIC_RST_WORD;
      down_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      down_ff <= nxt_down;
    end
  end

  // --------------------------------------------------------------------------
  // Capture input path
  // --------------------------------------------------------------------------
  // Software driving the pin's port output is seen here like any other edge.
  wire cap_src = (HAS_COMPARATOR && cmp_sel_ff) ? COMPARATOR_OUTPUT : CAPTURE_INPUT_PIN;
  wire cap_edge;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= cap_src;
      sync2_ff <= sync1_ff;
    end
  end

  tcic_noise_filter u_filter (
    .CLOCK     (CLOCK),
    .SRST      (SRST),
    .sample_in (sync2_ff),
    .filter_en (nf_en_ff),
    .rise_sel  (edge_rise_ff),
    .edge_out  (cap_edge)
  );

  wire cap_ev = cap_edge && !cap_top;
  // An unread value is simply replaced; there is no overrun indication.
  wire [15:0] nxt_cap = cap_ev ? cnt_ff :
                        ((wr_cap_lo && cap_top) ? {hold_ff, WDATA} : cap_ff);

  // --------------------------------------------------------------------------
  // Flags, set beats clear
  // --------------------------------------------------------------------------
  wire cap_clr = CAPTURE_IRQ_ACK || (wr_flags && WDATA[`TCIC_FLAG_CAP_BIT]);
  wire ovf_clr = OVERFLOW_IRQ_ACK || (wr_flags && WDATA[`TCIC_FLAG_OVF_BIT]);
  wire nxt_cap_flag = cap_ev || (cap_flag_ff && !cap_clr);
  wire nxt_ovf_flag = ovf_set || (ovf_flag_ff && !ovf_clr);

  // --------------------------------------------------------------------------
  // Holding byte and read data
  // --------------------------------------------------------------------------
  wire [7:0] nxt_hold = wr_hi_any ? WDATA :
                        (rd_cnt_lo ? cnt_ff[15:8] :
                        (rd_cap_lo ? cap_ff[15:8] : hold_ff));

  wire [7:0] ctrl_a_rd = {6'h00, wgm_lo_ff};
  wire [7:0] ctrl_b_rd = {nf_en_ff, edge_rise_ff, 1'b0, wgm_hi_ff, tick_sel_ff};
  wire [7:0] flags_rd  = {2'h0, cap_flag_ff, 4'h0, ovf_flag_ff};
  wire [7:0] irq_en_rd = {2'h0, cap_ie_ff, 4'h0, ovf_ie_ff};
  wire [7:0] cmp_cs_rd = {5'h00, cmp_sel_ff, 2'h0};
  // High-byte reads of counter and capture return the holding byte; compare A is direct.
  wire [7:0] rd_mux =
    hit(ADDR, `TCIC_ADDR_CTRL_A)  ? ctrl_a_rd :
    hit(ADDR, `TCIC_ADDR_CTRL_B)  ? ctrl_b_rd :
    hit(ADDR, `TCIC_ADDR_CNT_LO)  ? cnt_ff[7:0] :
    hit(ADDR, `TCIC_ADDR_CNT_HI)  ? hold_ff :
    hit(ADDR, `TCIC_ADDR_CAP_LO)  ? cap_ff[7:0] :
    hit(ADDR, `TCIC_ADDR_CAP_HI)  ? hold_ff :
    hit(ADDR, `TCIC_ADDR_CMPA_LO) ? cmpa_ff[7:0] :
    hit(ADDR, `TCIC_ADDR_CMPA_HI) ? cmpa_ff[15:8] :
    hit(ADDR, `TCIC_ADDR_FLAGS)   ? flags_rd :
    hit(ADDR, `TCIC_ADDR_IRQ_EN)  ? irq_en_rd :
    hit(ADDR, `TCIC_ADDR_CMP_CS)  ? cmp_cs_rd : `TCIC_RST_BYTE;

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wgm_lo_ff    <= 2'h0;
      wgm_hi_ff    <= 2'h0;
      tick_sel_ff  <= `TCIC_CS_STOP;
      edge_rise_ff <= 1'b0;
      nf_en_ff     <= 1'b0;
      cap_ie_ff    <= 1'b0;
      ovf_ie_ff    <= 1'b0;
      cmp_sel_ff   <= 1'b0;
    end else begin
      if (wr_ctrl_a) begin
        wgm_lo_ff <= WDATA[`TCIC_CA_WGM_MSB:0];
      end
      if (wr_ctrl_b) begin
        wgm_hi_ff    <= WDATA[`TCIC_CB_WGM_MSB:`TCIC_CB_WGM_LSB];
        tick_sel_ff  <= WDATA[`TCIC_CB_CS_MSB:0];
        edge_rise_ff <= WDATA[`TCIC_CB_EDGE_BIT];
        nf_en_ff     <= WDATA[`TCIC_CB_NF_BIT];
      end
      if (wr_irq_en) begin
        cap_ie_ff <= WDATA[`TCIC_FLAG_CAP_BIT];
        ovf_ie_ff <= WDATA[`TCIC_FLAG_OVF_BIT];
      end
      if (wr_cmp_cs) begin
        cmp_sel_ff <= HAS_COMPARATOR && WDATA[`TCIC_CS_COMPARATOR_CAPTURE_SELECT_BIT];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      cap_ff      <= `TCIC_RST_WORD;
      cmpa_ff     <= `TCIC_RST_WORD;
      hold_ff     <= `TCIC_RST_BYTE;
      cap_flag_ff <= 1'b0;
      ovf_flag_ff <= 1'b0;
      rdata_ff    <= `TCIC_RST_BYTE;
    end else begin
      cap_ff      <= nxt_cap;
      cmpa_ff     <= wr_cmpa_lo ? {hold_ff, WDATA} : cmpa_ff;
      hold_ff     <= nxt_hold;
      cap_flag_ff <= nxt_cap_flag;
      ovf_flag_ff <= nxt_ovf_flag;
      rdata_ff    <= RD_EN ? rd_mux : rdata_ff;
    end
  end

  assign RDATA        = rdata_ff;
  assign CAPTURE_IRQ  = cap_flag_ff && cap_ie_ff;
  assign OVERFLOW_IRQ = ovf_flag_ff && ovf_ie_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  property p_stopped;
    tick_sel_ff == `TCIC_CS_STOP && !wr_cnt_lo |=> cnt_ff == $past(cnt_ff);
  endproperty
  a_stopped: assert property (p_stopped) else $error("Counter moved while stopped.");

  property p_count_up;
    tick && wgm == TCIC_WGM_NORMAL && !wr_cnt_lo |=> cnt_ff == 16'($past(cnt_ff) + 16'h0001);
  endproperty
  a_count_up: assert property (p_count_up) else $error("Normal mode tick did not add one.");

  property p_cnt_write;
    wr_cnt_lo |=> cnt_ff == {$past(hold_ff), $past(WDATA)};
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("Counter write did not load holding and data.");

  property p_cnt_read_hold;
    rd_cnt_lo && !WR_EN |=> hold_ff == $past(cnt_ff[15:8]) ##1 1'b1;
  endproperty
  a_cnt_read_hold: assert property (p_cnt_read_hold) else $error("Counter low read missed high byte.");

  property p_capture;
    cap_ev |=> cap_ff == $past(cnt_ff) && cap_flag_ff;
  endproperty
  a_capture: assert property (p_capture) else $error("Capture did not store counter and flag.");

  property p_set_wins;
    cap_ev && cap_clr |=> cap_flag_ff;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Capture lost against a clear.");

  property p_cap_write_gate;
    wr_cap_lo && !cap_top && !cap_ev |=> cap_ff == $past(cap_ff);
  endproperty
  a_cap_write_gate: assert property (p_cap_write_gate) else $error("Capture written in wrong mode.");

  property p_cap_off;
    cap_top && !wr_cap_lo && !cap_flag_ff |=> cap_ff == $past(cap_ff) && !cap_flag_ff;
  endproperty
  a_cap_off: assert property (p_cap_off) else $error("Capture taken in capture-top mode.");

  property p_ovf_normal;
    tick && wgm == TCIC_WGM_NORMAL && !wr_cnt_lo && cnt_ff == `TCIC_MAX |=> ovf_flag_ff && cnt_ff == `TCIC_BOTTOM;
  endproperty
  a_ovf_normal: assert property (p_ovf_normal) else $error("Overflow not flagged at wrap.");

  property p_irq_clear;
    CAPTURE_IRQ && CAPTURE_IRQ_ACK && !cap_ev |=> !cap_flag_ff ##1 1'b1;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("Serviced capture flag not cleared.");

  c_capture:   cover property (cap_ev);
  c_cap_filt:  cover property (nf_en_ff && cap_ev);
  c_ovf_dual:  cover property (dual && ovf_set);
  c_cnt_write: cover property (wr_cnt_lo && tick);

endmodule

// file: testbench/tcic_event_src.sv
// Behavioural source of external events on the capture pin.
`timescale 1ns/10ps

module tcic_event_src (
  input  wire logic CLOCK,
  output logic      PIN
);
  // The pin idles low.
  // Changes land just after a rising edge, so the synchroniser never sees a tie with the clock.
  initial PIN = 1'b0;

  task automatic set_level(input logic lvl);
    @(posedge CLOCK);
    PIN <= lvl;
  endtask

  // A pulse narrower than four samples is noise that the filter has to reject.
  task automatic glitch(input int width);
    @(posedge CLOCK);
    PIN <= ~PIN;
    repeat (width) @(posedge CLOCK);
    PIN <= ~PIN;
  endtask
endmodule

// file: testbench/timer16_counter_input_capture_tb.sv
// Self-checking bench for the 16-bit capture timer.
`timescale 1ns/10ps
`include "tcic_consts.svh"

module timer16_counter_input_capture_tb
  import tcic_pkg::*;
;
  logic        clock, srst, wr_en, rd_en, cmp_out, cap_ack, ovf_ack, pin, cap_irq, ovf_irq;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [6:0]  tick;
  logic [15:0] rv;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          lat_raw, lat_filt;

  tcic_timer #(.HAS_COMPARATOR(1'b1)) DUT (.CLOCK(clock), .SRST(srst), .ADDR(addr), .WR_EN(wr_en),
    .RD_EN(rd_en), .WDATA(wdata), .RDATA(rdata), .TICK_IN(tick), .CAPTURE_INPUT_PIN(pin),
    .COMPARATOR_OUTPUT(cmp_out), .CAPTURE_IRQ(cap_irq), .CAPTURE_IRQ_ACK(cap_ack),
    .OVERFLOW_IRQ(ovf_irq), .OVERFLOW_IRQ_ACK(ovf_ack));
  tcic_event_src EVT (.CLOCK(clock), .PIN(pin));
  tcic_event_src CMP (.CLOCK(clock), .PIN(cmp_out));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // --------------------------------------------------------------------------
  // Register port and compare helpers
  // --------------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // The trailing delay lets flag updates of the taking edge settle before anyone looks.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= ~w;
    @(posedge clock);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    bus(1'b0, a, 8'h00);
    d = rdata;
  endtask

  // Services one request: 1 acknowledges the capture, 0 the overflow.
  task automatic ack(input logic cap);
    @(posedge clock);
    cap_ack <= cap;
    ovf_ack <= ~cap;
    @(posedge clock);
    cap_ack <= 1'b0;
    ovf_ack <= 1'b0;
    #1;
  endtask

  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 4'h1, v[15:8]);
  endtask

  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic pulse_tick(input logic [6:0] t);
    @(posedge clock);
    tick <= t;
    @(posedge clock);
    tick <= 7'h00;
  endtask

  task automatic wait_cap(output int n);
    n = 0;
    repeat (30) begin
      @(posedge clock);
      #1;
      n++;
      if (cap_irq === 1'b1) break;
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_counter;
    rd16(`TCIC_ADDR_CNT_LO, rv);
    chk(rv, `TCIC_RST_WORD, "counter after reset");
    rd(4'hB, rv[7:0]);
    chk({8'h00, rv[7:0]}, 16'h0000, "unmapped read");
    pulse_tick(7'h7F);
    wr16(`TCIC_ADDR_CNT_LO, 16'h01FF);
    rd16(`TCIC_ADDR_CNT_LO, rv);
    chk(rv, 16'h01FF, "stopped counter write");
    wr(`TCIC_ADDR_CTRL_B, 8'h01);
    repeat (3) pulse_tick(7'h01);
    pulse_tick(7'h02);
    rd16(`TCIC_ADDR_CNT_LO, rv);
    chk(rv, 16'h0202, "counted ticks");
    wr(`TCIC_ADDR_CNT_HI, 8'h12);
    @(posedge clock);
    addr <= `TCIC_ADDR_CNT_LO;
    wdata <= 8'h34;
    wr_en <= 1'b1;
    tick <= 7'h01;
    @(posedge clock);
    wr_en <= 1'b0;
    tick <= 7'h00;
    rd16(`TCIC_ADDR_CNT_LO, rv);
    chk(rv, 16'h1234, "write against tick");
    wr(`TCIC_ADDR_CTRL_B, 8'h00);
    $display("test counter done");
  endtask

  task automatic t_overflow;
    wr16(`TCIC_ADDR_CNT_LO, `TCIC_MAX);
    wr(`TCIC_ADDR_IRQ_EN, 8'h21);
    wr(`TCIC_ADDR_CTRL_B, 8'h01);
    pulse_tick(7'h01);
    wr(`TCIC_ADDR_CTRL_B, 8'h00);
    chk(16'(ovf_irq), 16'h0001, "overflow request");
    rd16(`TCIC_ADDR_CNT_LO, rv);
    chk(rv, `TCIC_BOTTOM, "wrapped counter");
    ack(1'b0);
    chk(16'(ovf_irq), 16'h0000, "overflow serviced");
    wr16(`TCIC_ADDR_CNT_LO, 16'h00FE);
    wr(`TCIC_ADDR_CTRL_A, 8'h01);
    wr(`TCIC_ADDR_CTRL_B, 8'h01);
    repeat (3) pulse_tick(7'h01);
    rd16(`TCIC_ADDR_CNT_LO, rv);
    chk(rv, 16'h00FD, "dual slope turns at fixed top");
    wr16(`TCIC_ADDR_CNT_LO, 16'h0001);
    repeat (2) pulse_tick(7'h01);
    rd16(`TCIC_ADDR_CNT_LO, rv);
    chk(rv, 16'h0001, "dual slope turns at bottom");
    chk(16'(ovf_irq), 16'h0001, "overflow at bottom");
    wr(`TCIC_ADDR_CTRL_B, 8'h00);
    wr(`TCIC_ADDR_CTRL_A, 8'h00);
    wr(`TCIC_ADDR_FLAGS, 8'h01);
    $display("test overflow done");
  endtask

  task automatic t_capture(input logic [7:0] cb, output int n);
    int m;
    wr(`TCIC_ADDR_CTRL_B, cb);
    wr16(`TCIC_ADDR_CNT_LO, {cb, 8'h5A});
    wr(`TCIC_ADDR_FLAGS, 8'h21);
    EVT.set_level(1'b1);
    wait_cap(n);
    rd16(`TCIC_ADDR_CAP_LO, rv);
    chk(rv, {cb, 8'h5A}, "captured count");
    wr(`TCIC_ADDR_FLAGS, 8'h00);
    chk(16'(cap_irq), 16'h0001, "flag kept by zero write");
    wr(`TCIC_ADDR_FLAGS, 8'h20);
    chk(16'(cap_irq), 16'h0000, "flag cleared by one write");
    wr(`TCIC_ADDR_CTRL_B, cb & 8'hBF);
    wr(`TCIC_ADDR_FLAGS, 8'h20);
    EVT.set_level(1'b0);
    wait_cap(m);
    chk(16'(m), 16'(n), "falling edge capture");
    wr(`TCIC_ADDR_FLAGS, 8'h20);
    idle(10);
    $display("test capture done");
  endtask

  task automatic t_glitch;
    wr(`TCIC_ADDR_CTRL_B, 8'hC0);
    EVT.glitch(3);
    idle(12);
    chk(16'(cap_irq), 16'h0000, "filtered glitch");
    wr(`TCIC_ADDR_CTRL_B, 8'h40);
    wr16(`TCIC_ADDR_CNT_LO, 16'h0111);
    EVT.glitch(3);
    idle(8);
    chk(16'(cap_irq), 16'h0001, "unfiltered glitch");
    wr16(`TCIC_ADDR_CNT_LO, 16'h0222);
    EVT.glitch(3);
    idle(8);
    rd16(`TCIC_ADDR_CAP_LO, rv);
    chk(rv, 16'h0222, "unread value overwritten");
    wr(`TCIC_ADDR_FLAGS, 8'h20);
    $display("test glitch done");
  endtask

  task automatic t_comparator;
    wr(`TCIC_ADDR_CMP_CS, 8'h04);
    idle(6);
    wr(`TCIC_ADDR_FLAGS, 8'h20);
    EVT.glitch(4);
    idle(8);
    chk(16'(cap_irq), 16'h0000, "pin ignored");
    CMP.set_level(1'b1);
    idle(8);
    chk(16'(cap_irq), 16'h0001, "comparator capture");
    ack(1'b1);
    chk(16'(cap_irq), 16'h0000, "capture serviced");
    CMP.set_level(1'b0);
    wr(`TCIC_ADDR_CMP_CS, 8'h00);
    idle(6);
    wr(`TCIC_ADDR_FLAGS, 8'h20);
    $display("test comparator done");
  endtask

  task automatic t_cap_top(input tcic_wgm_t m);
    wr16(`TCIC_ADDR_CAP_LO, 16'h5555);
    rd16(`TCIC_ADDR_CAP_LO, rv);
    chk(rv, 16'h0222, "write outside top mode");
    wr(`TCIC_ADDR_CTRL_A, {6'h00, m[1:0]});
    wr(`TCIC_ADDR_CTRL_B, 8'h40 | {3'h0, m[3:2], 3'h0});
    EVT.glitch(3);
    idle(8);
    chk(16'(cap_irq), 16'h0000, "input off in top mode");
    wr16(`TCIC_ADDR_CAP_LO, 16'hABCD);
    rd16(`TCIC_ADDR_CAP_LO, rv);
    chk(rv, 16'hABCD, "top value written");
    $display("test capture top done");
  endtask

  initial begin
    srst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    tick = 7'h00;
    cap_ack = 1'b0;
    ovf_ack = 1'b0;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    t_counter;
    t_overflow;
    t_capture(8'h40, lat_raw);
    t_capture(8'hC0, lat_filt);
    chk(16'(lat_filt - lat_raw), 16'h0004, "filter delay");
    t_glitch;
    t_comparator;
    t_cap_top(TCIC_WGM_CTC_CAP);
    print_verdict;
  end

  // Cuts a hang short; the scenarios need well under a tenth of this span.
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    print_verdict;
  end
endmodule
